/* src/pwcsc_top.sv */
// pwm second channel start, stop, clear and output level control with apb registers
// Contract
// - idle select sets initial output: 0 high, 1 low; inversion also inverts it.
// - on pause, restore bit 0 holds output, 1 returns initial level.
// - in cooperation, pause behaviour follows the first channel's run bit.
// - in clear mode, inhibit bit 1 ignores external clear while flag high.
// - in cooperation, the first channel's clear inhibit governs.
// - run bit written 1 starts, written 0 stops; resets to 0.
// - output flag read only, resets 1, counter byte write forces it 1.
// - status bit reads 1 while counting, 0 stopped; resets 0.
// - start mode: 00 sw, 01 sw or ext, 10 ext only, 11 sw with clear.
// - sw or ext mode: 01 high starts low stops, 10 reversed; run still works.
// - ext only: 01 rising start falling stop clear, 10 reversed.
// - ext only with code 00 or 11: channel never operates.
// - clear mode: run controls; clear on fall 01, rise 10, both 11.
// - sw mode, or sw or ext with 00 or 11: only run bit acts.
// - pin select 0 first event pin, 1 second; cooperation uses pair select.
// - in cooperation, own edge and start mode settings are disregarded.
// - one shot bit 0 repeat, 1 one shot; cooperation uses pair bit.
// - one shot stops after one period; repeat keeps running.
// - cooperation without dead time shares pair timebase, own duty value.
// - cooperation with dead time leaves an interval with both outputs off.
// - invert bit 0 positive, 1 negative; initial output 1 or 0.
// - trigger sampled on oscillator tick for fast timebase, else low speed tick.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pwcsc_top
  import pwcsc_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  // apb slave
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [pwcsc_pkg::PWCSC_AW-1:0] paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  input  wire logic [3:0]                   pstrb_in,
  output logic                              pready_out,
  output logic [31:0]                       prdata_out,
  output logic                              pslverr_out,
  // clock enables
  input  wire logic                         low_speed_clock_tick_in,
  input  wire logic                         high_speed_timebase_clock_tick_in,
  input  wire logic                         external_clock_tick_in,
  input  wire logic                         oscillator_clock_tick_in,
  // period and duty buffers
  input  wire logic [DW-1:0]                period_buf_in,
  input  wire logic [DW-1:0]                duty_buf_in,
  // first channel settings
  input  wire logic                         cooperation_mode_select_in,
  input  wire logic                         dead_time_use_in,
  input  wire logic                         pair_run_bit_in,
  input  wire logic                         pair_clear_inhibit_in,
  input  wire logic                         pair_trigger_pin_select_in,
  input  wire logic                         pair_one_shot_select_in,
  input  wire logic [1:0]                   pair_start_mode_in,
  input  wire logic [1:0]                   pair_trigger_edge_in,
  input  wire logic [DW-1:0]                pair_count_in,
  input  wire logic                         pair_output_flag_in,
  // event pins
  input  wire logic                         event_pin_first_in,
  input  wire logic                         event_pin_second_in,
  // channel outputs
  output logic                              pwm_out,
  output logic                              count_active_out,
  output logic                              output_flag_out
);
  import pwcsc_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic          run;
    logic          stat;
    logic          flag;
    logic [DW-1:0] cnt;
    logic [DW-1:0] dcnt;
    logic [7:0]    ocfg;
    logic [7:0]    tcfg;
    logic          ext_go;
    logic          trig;
    logic          trig_prev;
    logic          out;
    logic [31:0]   rdata;
    logic          err;
  } pwcsc_state_t;

  pwcsc_state_t s_q;
  pwcsc_state_t s_d;

  function automatic logic addr_hit(input logic [PWCSC_AW-1:0] a, input logic [15:0] idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction

  // -------------------------------------------------------------------
  // effective settings
  // -------------------------------------------------------------------
  logic       coop;
  logic [1:0] stm;
  logic [1:0] tge;
  logic       pin_sel;
  logic       one_shot;
  logic       clr_inh;
  logic       init_lvl;
  logic       run_eff;
  logic       samp;
  logic       pt;
  logic       rise;
  logic       fall;
  logic       go;
  logic       clr_edge;
  logic       clr_ok;
  logic       paused;
  logic       wr;
  logic       rd;
  logic       cnt_wr;
  logic       per_hit;

  assign coop     = cooperation_mode_select_in;
  assign stm      = coop ? pair_start_mode_in : s_q.tcfg[PWCSC_TC_STM +: 2];
  assign tge      = coop ? pair_trigger_edge_in : s_q.tcfg[PWCSC_TC_TGE +: 2];
  assign pin_sel  = coop ? pair_trigger_pin_select_in : s_q.tcfg[PWCSC_TC_TGSEL];
  assign one_shot = coop ? pair_one_shot_select_in : s_q.tcfg[PWCSC_TC_MD];
  assign clr_inh  = coop ? pair_clear_inhibit_in : s_q.ocfg[PWCSC_OC_CLIG];
  assign init_lvl = ~s_q.ocfg[PWCSC_OC_INI] ^ s_q.ocfg[PWCSC_OC_NEG];
  assign run_eff  = coop ? pair_run_bit_in : s_q.run;

  assign samp = (s_q.ocfg[PWCSC_OC_CS +: 2] == PWCSC_CS_HTB) ? oscillator_clock_tick_in
                                                              : low_speed_clock_tick_in;
  always_comb begin
    case (s_q.ocfg[PWCSC_OC_CS +: 2])
      PWCSC_CS_LS:  pt = low_speed_clock_tick_in;
      PWCSC_CS_HTB: pt = high_speed_timebase_clock_tick_in;
      PWCSC_CS_EXT: pt = external_clock_tick_in;
      default:      pt = 1'b0;
    endcase
  end

  assign rise = samp & s_q.trig & ~s_q.trig_prev;
  assign fall = samp & ~s_q.trig & s_q.trig_prev;

  // -------------------------------------------------------------------
  // start mode decode
  // -------------------------------------------------------------------
  always_comb begin
    go       = 1'b0;
    clr_edge = 1'b0;
    case (stm)
      PWCSC_STM_SW: begin
        go = run_eff;
      end
      PWCSC_STM_SW_EXT: begin
        if (tge == PWCSC_TGE_POS) begin
          go       = run_eff | s_q.trig;
          clr_edge = fall & ~run_eff;
        end else if (tge == PWCSC_TGE_NEG) begin
          go       = run_eff | ~s_q.trig;
          clr_edge = rise & ~run_eff;
        end else begin
          go = run_eff;
        end
      end
      PWCSC_STM_EXT: begin
        if (tge == PWCSC_TGE_POS || tge == PWCSC_TGE_NEG) begin
          go = s_q.ext_go;
        end
        if (tge == PWCSC_TGE_POS) begin
          clr_edge = fall;
        end else if (tge == PWCSC_TGE_NEG) begin
          clr_edge = rise;
        end
      end
      default: begin
        go = run_eff;
        if (tge == PWCSC_TGE_POS) begin
          clr_edge = fall;
        end else if (tge == PWCSC_TGE_NEG) begin
          clr_edge = rise;
        end else if (tge == PWCSC_TGE_BOTH) begin
          clr_edge = rise | fall;
        end
      end
    endcase
  end

  assign clr_ok  = clr_edge & ~((stm == PWCSC_STM_SW_CLR) & clr_inh & s_q.flag);
  assign paused  = ~run_eff & ~go;
  assign wr      = psel_in & penable_in & pwrite_in;
  assign rd      = psel_in & penable_in & ~pwrite_in;
  assign cnt_wr  = wr & pstrb_in[0] & (addr_hit(paddr_in, PWCSC_IDX_CNT_LO) | addr_hit(paddr_in, PWCSC_IDX_CNT_HI));
  assign per_hit = (s_q.cnt == period_buf_in);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // trigger sampling
    if (samp) begin
      s_d.trig      = pin_sel ? event_pin_second_in : event_pin_first_in;
      s_d.trig_prev = s_q.trig;
    end
    // external start and stop in ext only mode
    if (stm == PWCSC_STM_EXT) begin
      if ((tge == PWCSC_TGE_POS && rise) || (tge == PWCSC_TGE_NEG && fall)) begin
        s_d.ext_go = 1'b1;
      end else if (clr_edge) begin
        s_d.ext_go = 1'b0;
      end
    end else begin
      s_d.ext_go = 1'b0;
    end
    // counting
    if (coop) begin
      s_d.stat = pair_run_bit_in;
      if (pt) begin
        if (dead_time_use_in) begin
          if (pair_output_flag_in) begin
            s_d.dcnt = '0;
          end else if (s_q.dcnt != duty_buf_in) begin
            s_d.dcnt = s_q.dcnt + 1'b1;
          end
          s_d.flag = ~pair_output_flag_in & (s_q.dcnt == duty_buf_in);
        end else begin
          s_d.flag = (pair_count_in <= duty_buf_in);
        end
      end
    end else if (pt) begin
      s_d.stat = go;
      if (s_q.stat && go) begin
        if (s_q.cnt == duty_buf_in) begin
          s_d.flag = 1'b0;
        end
        if (per_hit) begin
          s_d.flag = 1'b1;
          s_d.cnt  = '0;
          if (one_shot) begin
            s_d.run    = 1'b0;
            s_d.ext_go = 1'b0;
            s_d.stat   = 1'b0;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    end
    if (clr_ok) begin
      s_d.cnt  = '0;
      s_d.flag = 1'b1;
    end
    // output level
    if (!paused || s_q.stat) begin
      s_d.out = s_d.flag ^ s_q.ocfg[PWCSC_OC_INI] ^ s_q.ocfg[PWCSC_OC_NEG];
    end else if (s_q.ocfg[PWCSC_OC_STPS]) begin
      s_d.out = init_lvl;
    end
    // register writes
    if (wr && pstrb_in[0]) begin
      if (addr_hit(paddr_in, PWCSC_IDX_OUT_CFG)) begin
        s_d.ocfg = pwdata_in[7:0];
        if (!s_q.stat) begin
          s_d.out = ~pwdata_in[PWCSC_OC_INI] ^ pwdata_in[PWCSC_OC_NEG];
        end
      end else if (addr_hit(paddr_in, PWCSC_IDX_RUN_STAT)) begin
        s_d.run = pwdata_in[PWCSC_RS_RUN];
      end else if (addr_hit(paddr_in, PWCSC_IDX_TRG_CFG)) begin
        s_d.tcfg = pwdata_in[7:0] & PWCSC_TC_MASK;
      end
    end
    if (cnt_wr) begin
      s_d.cnt  = '0;
      s_d.flag = 1'b1;
    end
    // register reads
    s_d.err   = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (psel_in && !penable_in) begin
      if (addr_hit(paddr_in, PWCSC_IDX_OUT_CFG)) begin
        s_d.rdata[7:0] = s_q.ocfg;
      end else if (addr_hit(paddr_in, PWCSC_IDX_RUN_STAT)) begin
        s_d.rdata[PWCSC_RS_STAT] = s_q.stat;
        s_d.rdata[PWCSC_RS_FLG]  = s_q.flag;
        s_d.rdata[PWCSC_RS_RUN]  = s_q.run;
      end else if (addr_hit(paddr_in, PWCSC_IDX_TRG_CFG)) begin
        s_d.rdata[7:0] = s_q.tcfg & PWCSC_TC_MASK;
      end else if (addr_hit(paddr_in, PWCSC_IDX_CNT_LO)) begin
        s_d.rdata[7:0] = s_q.cnt[7:0];
      end else if (addr_hit(paddr_in, PWCSC_IDX_CNT_HI)) begin
        s_d.rdata[7:0] = s_q.cnt[DW-1:8];
      end else begin
        s_d.err = 1'b1;
      end
    end else if (psel_in) begin
      s_d.rdata = s_q.rdata;
      s_d.err   = s_q.err;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q           <= '0;
      s_q.flag      <= PWCSC_RST_RUN_STAT[PWCSC_RS_FLG];
      s_q.ocfg      <= PWCSC_RST_OUT_CFG;
      s_q.tcfg      <= PWCSC_RST_TRG_CFG;
      s_q.out       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign pready_out       = 1'b1;
  assign prdata_out       = s_q.rdata;
  assign pslverr_out      = psel_in & penable_in & s_q.err;
  assign pwm_out          = s_q.out;
  assign count_active_out = s_q.stat;
  assign output_flag_out  = s_q.flag;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_flag_on_cwr: assert property (cnt_wr |=> s_q.flag && s_q.cnt == '0)
    else $error("counter write did not set flag");
  chk_run_write: assert property (wr && pstrb_in[0] && addr_hit(paddr_in, PWCSC_IDX_RUN_STAT)
    |=> s_q.run == $past(pwdata_in[0]))
    else $error("run bit write lost");
  chk_status_read: assert property (psel_in && !penable_in && addr_hit(paddr_in, PWCSC_IDX_RUN_STAT)
    |=> prdata_out[7] == $past(s_q.stat) && prdata_out[6] == $past(s_q.flag))
    else $error("status read mismatch");
  chk_restore_lvl: assert property (paused && !s_q.stat && s_q.ocfg[6] && !wr
    |=> pwm_out == $past(init_lvl))
    else $error("paused output not restored");
  chk_hold_lvl: assert property (paused && !s_q.stat && !s_q.ocfg[6] && !wr
    |=> $stable(pwm_out))
    else $error("paused output not held");
  chk_ext_dead: assert property (!coop && stm == PWCSC_STM_EXT && (tge == 2'b00 || tge == 2'b11) && pt
    |=> !s_q.stat)
    else $error("ext only mode ran with bad edge code");
  chk_clr_inhibit: assert property (!coop && stm == PWCSC_STM_SW_CLR && clr_inh && s_q.flag |-> !clr_ok)
    else $error("external clear not inhibited");
  chk_reserved_zero: assert property (psel_in && !penable_in && addr_hit(paddr_in, PWCSC_IDX_TRG_CFG)
    |=> prdata_out[7] == 1'b0 && prdata_out[5] == 1'b0)
    else $error("reserved bits read nonzero");
  chk_oneshot_stop: assert property (!coop && pt && s_q.stat && go && per_hit && one_shot && !wr
    |=> !s_q.run && !s_q.stat)
    else $error("one shot did not stop");

  cov_oneshot: cover property (!coop && pt && s_q.stat && per_hit && one_shot);
  cov_ext_start: cover property (stm == PWCSC_STM_EXT && rise ##[1:50] s_q.stat);
  cov_ext_clear: cover property (clr_ok);
  cov_dead_time: cover property (coop && dead_time_use_in && s_q.flag);
  cov_bad_read: cover property (rd && pslverr_out);
endmodule
`default_nettype wire

/* src/pwcsc_pkg.sv */
// package: register map, field positions, reset values and mode codes of the channel control block
package pwcsc_pkg;
  // -------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------------
  localparam logic [15:0] PWCSC_IDX_CNT_LO   = 16'hf8b4;
  localparam logic [15:0] PWCSC_IDX_CNT_HI   = 16'hf8b5;
  localparam logic [15:0] PWCSC_IDX_OUT_CFG  = 16'hf8b6;
  localparam logic [15:0] PWCSC_IDX_RUN_STAT = 16'hf8b7;
  localparam logic [15:0] PWCSC_IDX_TRG_CFG  = 16'hf8b8;
  localparam int          PWCSC_AW           = 18;
  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0]  PWCSC_RST_OUT_CFG  = 8'h00;
  localparam logic [7:0]  PWCSC_RST_RUN_STAT = 8'h40;
  localparam logic [7:0]  PWCSC_RST_TRG_CFG  = 8'h00;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int PWCSC_OC_CLIG  = 7;
  localparam int PWCSC_OC_STPS  = 6;
  localparam int PWCSC_OC_INI   = 5;
  localparam int PWCSC_OC_NEG   = 4;
  localparam int PWCSC_OC_CS    = 0;
  localparam int PWCSC_RS_STAT  = 7;
  localparam int PWCSC_RS_FLG   = 6;
  localparam int PWCSC_RS_RUN   = 0;
  localparam int PWCSC_TC_MD    = 6;
  localparam int PWCSC_TC_TGSEL = 4;
  localparam int PWCSC_TC_STM   = 2;
  localparam int PWCSC_TC_TGE   = 0;
  localparam logic [7:0] PWCSC_TC_MASK = 8'h5f;
  // -------------------------------------------------------------------
  // mode codes
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWCSC_STM_SW     = 2'b00,
    PWCSC_STM_SW_EXT = 2'b01,
    PWCSC_STM_EXT    = 2'b10,
    PWCSC_STM_SW_CLR = 2'b11
  } pwcsc_stm_t;
  localparam logic [1:0] PWCSC_TGE_OFF  = 2'b00;
  localparam logic [1:0] PWCSC_TGE_POS  = 2'b01;
  localparam logic [1:0] PWCSC_TGE_NEG  = 2'b10;
  localparam logic [1:0] PWCSC_TGE_BOTH = 2'b11;
  localparam logic [1:0] PWCSC_CS_HTB   = 2'b01;
  localparam logic [1:0] PWCSC_CS_EXT   = 2'b10;
  localparam logic [1:0] PWCSC_CS_LS    = 2'b00;
endpackage

/* test/pwcsc_ext_model.sv */
// far side model: clock enables, sample ticks and event pins
`timescale 1ns/1ps
`default_nettype none
module pwcsc_ext_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // requested pin levels
  input  wire logic evt_first_cmd_in,
  input  wire logic evt_second_cmd_in,
  // clock enables
  output logic      ls_tick_out,
  output logic      htb_tick_out,
  output logic      ext_tick_out,
  output logic      osc_tick_out,
  // event pins
  output logic      event_pin_first_out,
  output logic      event_pin_second_out
);
  logic [1:0] div_q;
  // ---------------------------------------------------------------
  // tick divider and synchronous pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q                <= 2'h0;
      event_pin_first_out  <= 1'b0;
      event_pin_second_out <= 1'b0;
    end else begin
      div_q                <= div_q + 2'h1;
      event_pin_first_out  <= evt_first_cmd_in;
      event_pin_second_out <= evt_second_cmd_in;
    end
  end
  assign ls_tick_out  = (div_q == 2'h3);
  assign htb_tick_out = div_q[0];
  assign ext_tick_out = (div_q == 2'h1);
  assign osc_tick_out = ~div_q[0];
endmodule
`default_nettype wire

/* test/pwm_channel_start_stop_control_tb.sv */
// self-checking bench of the channel start, stop and output control block
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_start_stop_control_tb;
  import pwcsc_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err;
  logic [3:0]  pstrb = 4'hf;
  logic        ls_t, htb_t, ext_t, osc_t, pin_f, pin_s, evt_f = 1'b0, evt_s = 1'b0;
  logic [15:0] period = 16'h0003, duty = 16'h0001, pcnt = 16'h0000;
  logic        coop = 1'b0, prun = 1'b0, pclig = 1'b0, pflag = 1'b1, lv;
  logic        pwm, act, flag;
  logic [11:0] tbl [0:16];
  integer      seed = 94;
  int          n_errors = 0;
  int          check_count = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  pwcsc_ext_model ext_m (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .evt_first_cmd_in(evt_f),
    .evt_second_cmd_in(evt_s), .ls_tick_out(ls_t), .htb_tick_out(htb_t), .ext_tick_out(ext_t),
    .osc_tick_out(osc_t), .event_pin_first_out(pin_f), .event_pin_second_out(pin_s));
  pwcsc_top uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .low_speed_clock_tick_in(ls_t),
    .high_speed_timebase_clock_tick_in(htb_t), .external_clock_tick_in(ext_t),
    .oscillator_clock_tick_in(osc_t), .period_buf_in(period), .duty_buf_in(duty),
    .cooperation_mode_select_in(coop), .dead_time_use_in(1'b0), .pair_run_bit_in(prun),
    .pair_clear_inhibit_in(pclig), .pair_trigger_pin_select_in(1'b0), .pair_one_shot_select_in(1'b0),
    .pair_start_mode_in(2'b00), .pair_trigger_edge_in(2'b00), .pair_count_in(pcnt),
    .pair_output_flag_in(pflag), .event_pin_first_in(pin_f), .event_pin_second_in(pin_s),
    .pwm_out(pwm), .count_active_out(act), .output_flag_out(flag));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic init_level(input logic idle, input logic inv);
    return ~idle ^ inv;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, {24'h00_0000, exp}, rd);
  endtask
  task automatic wait_act(input logic exp, input int lim);
    int n;
    n = 0;
    while (act !== exp && n < lim) begin
      @(posedge sys_clk_in);
      n++;
    end
    check("count_active", {31'h0, exp}, {31'h0, act});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(100 * 60000);
    n_errors++;
    close_out();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    // {config, first pin, second pin, expected active, fixed wait}
    tbl = '{{8'h08, 4'b1001}, {8'h08, 4'b0001}, {8'h0b, 4'b1001}, {8'h0b, 4'b0001}, {8'h09, 4'b1010},
            {8'h09, 4'b0000}, {8'h0a, 4'b1001}, {8'h0a, 4'b0010}, {8'h0a, 4'b1000}, {8'h19, 4'b0001},
            {8'h19, 4'b1001}, {8'h19, 4'b1110}, {8'h19, 4'b1000}, {8'h05, 4'b1010}, {8'h05, 4'b0000},
            {8'h06, 4'b0010}, {8'h06, 4'b1000}};
    pcnt <= 16'($random(seed));
    pflag <= 1'($random(seed));
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    check("pwm_out", 32'h1, {31'h0, pwm});
    rd_chk("run_status", PWCSC_IDX_RUN_STAT, PWCSC_RST_RUN_STAT);
    rd_chk("trigger_config", PWCSC_IDX_TRG_CFG, 8'h00);
    rd_chk("output_config", PWCSC_IDX_OUT_CFG, 8'h00);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'hfe);
    rd_chk("run_status", PWCSC_IDX_RUN_STAT, 8'h40);
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'hff);
    rd_chk("trigger_config", PWCSC_IDX_TRG_CFG, 8'h5f);
    apb(1'b0, 16'hf8c0, 8'h00);
    check("unmapped_err", 32'h1, {31'h0, err});
    check("unmapped_data", 32'h0, rd);
    pstrb <= 4'h0;
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h01);
    pstrb <= 4'hf;
    rd_chk("strobe_off_write", PWCSC_IDX_RUN_STAT, 8'h40);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PWCSC_IDX_OUT_CFG, {2'b00, i[1], i[0], 4'h0});
      repeat (3) @(posedge sys_clk_in);
      check("pwm_init", {31'h0, init_level(i[1], i[0])}, {31'h0, pwm});
    end
    period <= 16'h0003 + 16'($random(seed) & 7);
    duty <= 16'h0002;
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'h40);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h01);
    wait_act(1'b1, 40);
    wait_act(1'b0, 4 * period + 80);
    rd_chk("run_status", PWCSC_IDX_RUN_STAT, 8'h40);
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'h00);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h01);
    wait_act(1'b1, 40);
    repeat (8 * period + 40) @(posedge sys_clk_in);
    check("repeat_active", 32'h1, {31'h0, act});
    for (int i = 0; i < 2; i++) begin
      while (flag !== 1'b0) @(posedge sys_clk_in);
      apb(1'b1, i ? PWCSC_IDX_CNT_HI : PWCSC_IDX_CNT_LO, 8'h5a);
      #1 check("output_flag", 32'h1, {31'h0, flag});
    end
    apb(1'b1, PWCSC_IDX_OUT_CFG, 8'h60);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h00);
    wait_act(1'b0, 40);
    repeat (3) @(posedge sys_clk_in);
    check("pause_level", {31'h0, init_level(1'b1, 1'b0)}, {31'h0, pwm});
    apb(1'b1, PWCSC_IDX_OUT_CFG, 8'h00);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h01);
    repeat (4 * period) @(posedge sys_clk_in);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h00);
    wait_act(1'b0, 40);
    lv = pwm;
    repeat (40) @(posedge sys_clk_in);
    check("pause_hold", {31'h0, lv}, {31'h0, pwm});
    foreach (tbl[k]) begin
      apb(1'b1, PWCSC_IDX_TRG_CFG, tbl[k][11:4]);
      evt_f <= tbl[k][3];
      evt_s <= tbl[k][2];
      if (tbl[k][0]) repeat (60) @(posedge sys_clk_in);
      wait_act(tbl[k][1], 60);
    end
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'h04);
    evt_f <= 1'b0;
    repeat (60) @(posedge sys_clk_in);
    wait_act(1'b0, 4);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h01);
    wait_act(1'b1, 40);
    apb(1'b1, PWCSC_IDX_RUN_STAT, 8'h00);
    wait_act(1'b0, 40);
    apb(1'b1, PWCSC_IDX_OUT_CFG, 8'h01);
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'h05);
    evt_f <= 1'b1;
    wait_act(1'b1, 6);
    evt_f <= 1'b0;
    wait_act(1'b0, 40);
    apb(1'b1, PWCSC_IDX_TRG_CFG, 8'h08);
    coop <= 1'b1;
    prun <= 1'b1;
    wait_act(1'b1, 40);
    prun <= 1'b0;
    wait_act(1'b0, 40);
    close_out();
  end
endmodule
`default_nettype wire
